// >>> ccsp_pkg.sv
// Function
// - Half-carry set on carry from bit 3 into bit 4 during add.
// - Half-carry cleared by add operations without carry from bit 3.
// - Negative flag copies result bit 7 of last data operation.
// - Zero flag set when last data result is all zeros.
// - Carry set on arithmetic overflow or underflow, else cleared.
// - Carry set/clear instructions force carry; bit test, shift, rotate update it.
// - Branch conditions test half-carry, negative, zero and carry, both senses.
// - Priority bits 5 and 3 encode levels 0..3 as 10, 01, 00, 11.
// - Interrupt entry loads priority bits from serviced vector's priority field.
// - Unmask, mask, interrupt return and condition code write change priority.
// - Whole condition code register can be pushed and popped.
// - Stack pointer addresses next free byte; post-decrement push, pre-increment pop.
// - Stack is 256 bytes; pointer high byte forced by hardware.
// - Reset and stack reinit instruction load pointer with 01ff.
// - Pointer low byte readable and writable by load instruction.
// - Pointer wraps at both limits without any overflow indication.
// - Interrupt save writes program counter low byte first, then lower addresses.
// - Call uses two stack bytes, interrupt context uses five.
// - Interrupt entry saves program counter, index, accumulator, condition code.
// - Interrupt return restores priority bits with rest of context.
package ccsp_pkg;
  // Condition code field positions
  localparam int CARRY_BIT = 0;
  localparam int ZERO_BIT = 1;
  localparam int NEG_BIT = 2;
  localparam int PRIO_LOW_BIT = 3;
  localparam int HALF_BIT = 4;
  localparam int PRIO_HIGH_BIT = 5;
  // Reset values
  localparam logic [7:0] CC_RESET = 8'hfa;
  localparam logic [7:0] CC_FIXED = 8'hc0;
  localparam logic [15:0] SP_RESET = 16'h01ff;
  localparam logic [7:0] SP_HIGH = 8'h01;
  // Frame sizes
  localparam logic [2:0] CALL_BYTES = 3'h2;
  localparam logic [2:0] IRQ_BYTES = 3'h5;
  // Priority codes
  localparam logic [1:0] PRIO_MAIN = 2'h2;
  localparam logic [1:0] PRIO_DISABLE = 2'h3;
  // Core operations
  typedef enum logic [3:0] {
    OP_NONE = 4'b0000, OP_ADD = 4'b0001, OP_ARITH = 4'b0010, OP_LOGIC = 4'b0011,
    OP_CARRY_SET = 4'b0100, OP_CARRY_CLR = 4'b0101, OP_SHIFT = 4'b0110,
    OP_UNMASK = 4'b0111, OP_MASK = 4'b1000, OP_CC_WRITE = 4'b1001,
    OP_SP_RESET = 4'b1010, OP_SP_LOAD = 4'b1011, OP_BITTEST = 4'b1100
  } op_e;
  // Stack sequences
  typedef enum logic [2:0] {
    SEQ_NONE = 3'b000, SEQ_PUSH = 3'b001, SEQ_POP = 3'b010, SEQ_CALL = 3'b011,
    SEQ_RET = 3'b100, SEQ_IRQ = 3'b101, SEQ_INTERRUPT_RETURN_INSTRUCTION = 3'b110
  } seq_e;
  // Branch conditions
  typedef enum logic [2:0] {
    BR_HALF = 3'b000, BR_NOHALF = 3'b001, BR_NEG = 3'b010, BR_POS = 3'b011,
    BR_ZERO = 3'b100, BR_NONZERO = 3'b101, BR_CARRY = 3'b110, BR_NOCARRY = 3'b111
  } br_e;
endpackage

// >>> cpu_flags_stack_pointer.sv
`timescale 1ns/10ps
module cpu_flags_stack_pointer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire ccsp_pkg::op_e opCode,
  input wire logic [7:0] result,
  input wire logic carryOut,
  input wire logic halfCarry,
  input wire logic [7:0] writeData,
  input wire ccsp_pkg::seq_e seqStart,
  input wire logic [1:0] vectorPriority,
  input wire logic [7:0] popData,
  input wire ccsp_pkg::br_e branchCond,
  output logic [7:0] condition_code_register,
  output logic [15:0] stack_top_pointer,
  output logic stackWrite,
  output logic stackRead,
  output logic [2:0] frameIndex,
  output logic seqBusy,
  output logic branchTaken
);
  //////////////////////////////////////////////////////////////////////
  // Stack sequencer
  logic [2:0] remaining;
  logic [2:0] frameLen;
  logic pushing;
  logic popIret;
  logic restoreNext;
  logic startPush;
  logic startPop;
  logic [2:0] startLen;
  logic [7:0] spLow;
  logic [7:0] ccStore;

  // Frame length and direction per sequence
  always_comb begin
    startPush = 1'b0;
    startPop = 1'b0;
    startLen = 3'h0;
    unique case (seqStart)
      ccsp_pkg::SEQ_PUSH: begin
        startPush = 1'b1;
        startLen = 3'h1;
      end
      ccsp_pkg::SEQ_POP: begin
        startPop = 1'b1;
        startLen = 3'h1;
      end
      ccsp_pkg::SEQ_CALL: begin
        startPush = 1'b1;
        startLen = ccsp_pkg::CALL_BYTES;
      end
      ccsp_pkg::SEQ_RET: begin
        startPop = 1'b1;
        startLen = ccsp_pkg::CALL_BYTES;
      end
      ccsp_pkg::SEQ_IRQ: begin
        startPush = 1'b1;
        startLen = ccsp_pkg::IRQ_BYTES;
      end
      ccsp_pkg::SEQ_INTERRUPT_RETURN_INSTRUCTION: begin
        startPop = 1'b1;
        startLen = ccsp_pkg::IRQ_BYTES;
      end
      ccsp_pkg::SEQ_NONE: begin
      end
    endcase
  end

  // Byte counter; one stack byte per cycle, requests refused while busy
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      remaining <= 3'h0;
      frameLen <= 3'h0;
      pushing <= 1'b0;
      popIret <= 1'b0;
    end else if (remaining != 3'h0) begin
      remaining <= remaining - 3'h1;
    end else if (startPush || startPop) begin
      remaining <= startLen;
      frameLen <= startLen;
      pushing <= startPush;
      popIret <= (seqStart == ccsp_pkg::SEQ_INTERRUPT_RETURN_INSTRUCTION);
    end
  end

  wire active = (remaining != 3'h0);
  wire doPush = active && pushing;
  wire doPop = active && !pushing;
  // First pop of an interrupt return is the last pushed byte: condition code
  wire firstIretPop = doPop && popIret && (remaining == ccsp_pkg::IRQ_BYTES);
  // Op path not overridden by a restore or a priority load
  wire opFree = !restoreNext && !(seqStart == ccsp_pkg::SEQ_IRQ && !active);

  // Restore strobe lines up with the read strobe of the condition code byte
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      restoreNext <= 1'b0;
    end else begin
      restoreNext <= firstIretPop;
    end
  end

  // Bus strobes; byte 0 of an interrupt frame is program counter low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stackWrite <= 1'b0;
      stackRead <= 1'b0;
      frameIndex <= 3'h0;
      seqBusy <= 1'b0;
    end else begin
      stackWrite <= doPush;
      stackRead <= doPop;
      frameIndex <= active ? frameSlot(pushing, frameLen, remaining) : 3'h0;
      seqBusy <= active || startPush || startPop;
    end
  end

  // Position of current byte in the frame, counted from first pushed
  function automatic logic [2:0] frameSlot(input logic p, input logic [2:0] len,
                                           input logic [2:0] r);
    frameSlot = p ? (len - r) : (r - 3'h1);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Stack pointer low byte, high byte forced
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      spLow <= ccsp_pkg::SP_RESET[7:0];
    end else if (doPush) begin
      spLow <= spLow - 8'h01;
    end else if (doPop) begin
      spLow <= spLow + 8'h01;
    end else if (opCode == ccsp_pkg::OP_SP_RESET) begin
      spLow <= ccsp_pkg::SP_RESET[7:0];
    end else if (opCode == ccsp_pkg::OP_SP_LOAD) begin
      spLow <= writeData;
    end
  end

  // Address presented: pre-increment on pop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stack_top_pointer <= ccsp_pkg::SP_RESET;
    end else if (doPop) begin
      stack_top_pointer <= {ccsp_pkg::SP_HIGH, spLow + 8'h01};
    end else begin
      stack_top_pointer <= {ccsp_pkg::SP_HIGH, spLow};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Condition code flags
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ccStore <= ccsp_pkg::CC_RESET;
    end else if (restoreNext) begin
      ccStore <= popData | ccsp_pkg::CC_FIXED;
    end else if (seqStart == ccsp_pkg::SEQ_IRQ && !active) begin
      ccStore[ccsp_pkg::PRIO_HIGH_BIT] <= vectorPriority[1];
      ccStore[ccsp_pkg::PRIO_LOW_BIT] <= vectorPriority[0];
    end else begin
      unique case (opCode)
        ccsp_pkg::OP_ADD: begin
          ccStore[ccsp_pkg::HALF_BIT] <= halfCarry;
          ccStore[ccsp_pkg::NEG_BIT] <= result[7];
          ccStore[ccsp_pkg::ZERO_BIT] <= (result == 8'h00);
          ccStore[ccsp_pkg::CARRY_BIT] <= carryOut;
        end
        ccsp_pkg::OP_ARITH, ccsp_pkg::OP_SHIFT: begin
          ccStore[ccsp_pkg::NEG_BIT] <= result[7];
          ccStore[ccsp_pkg::ZERO_BIT] <= (result == 8'h00);
          ccStore[ccsp_pkg::CARRY_BIT] <= carryOut;
        end
        ccsp_pkg::OP_LOGIC: begin
          ccStore[ccsp_pkg::NEG_BIT] <= result[7];
          ccStore[ccsp_pkg::ZERO_BIT] <= (result == 8'h00);
        end
        ccsp_pkg::OP_BITTEST: ccStore[ccsp_pkg::CARRY_BIT] <= carryOut;
        ccsp_pkg::OP_CARRY_SET: ccStore[ccsp_pkg::CARRY_BIT] <= 1'b1;
        ccsp_pkg::OP_CARRY_CLR: ccStore[ccsp_pkg::CARRY_BIT] <= 1'b0;
        ccsp_pkg::OP_UNMASK: begin
          ccStore[ccsp_pkg::PRIO_HIGH_BIT] <= ccsp_pkg::PRIO_MAIN[1];
          ccStore[ccsp_pkg::PRIO_LOW_BIT] <= ccsp_pkg::PRIO_MAIN[0];
        end
        ccsp_pkg::OP_MASK: begin
          ccStore[ccsp_pkg::PRIO_HIGH_BIT] <= ccsp_pkg::PRIO_DISABLE[1];
          ccStore[ccsp_pkg::PRIO_LOW_BIT] <= ccsp_pkg::PRIO_DISABLE[0];
        end
        ccsp_pkg::OP_CC_WRITE: begin
          ccStore <= writeData | ccsp_pkg::CC_FIXED;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      condition_code_register <= ccsp_pkg::CC_RESET;
    end else begin
      condition_code_register <= ccStore | ccsp_pkg::CC_FIXED;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Branch evaluation
  function automatic logic branchTest(input ccsp_pkg::br_e c, input logic [7:0] cc);
    unique case (c)
      ccsp_pkg::BR_HALF: branchTest = cc[ccsp_pkg::HALF_BIT];
      ccsp_pkg::BR_NOHALF: branchTest = !cc[ccsp_pkg::HALF_BIT];
      ccsp_pkg::BR_NEG: branchTest = cc[ccsp_pkg::NEG_BIT];
      ccsp_pkg::BR_POS: branchTest = !cc[ccsp_pkg::NEG_BIT];
      ccsp_pkg::BR_ZERO: branchTest = cc[ccsp_pkg::ZERO_BIT];
      ccsp_pkg::BR_NONZERO: branchTest = !cc[ccsp_pkg::ZERO_BIT];
      ccsp_pkg::BR_CARRY: branchTest = cc[ccsp_pkg::CARRY_BIT];
      ccsp_pkg::BR_NOCARRY: branchTest = !cc[ccsp_pkg::CARRY_BIT];
    endcase
  endfunction

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      branchTaken <= 1'b0;
    end else begin
      branchTaken <= branchTest(branchCond, ccStore);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks
  // Fixed bits and pointer shape
  a_fixed_bits: assert property (@(posedge clk_sys) disable iff (rst)
    condition_code_register[7:6] == 2'b11) else $error("fixed bits not one");
  a_sp_high: assert property (@(posedge clk_sys) disable iff (rst)
    stack_top_pointer[15:8] == ccsp_pkg::SP_HIGH) else $error("pointer high byte changed");

  // Pointer movement
  a_push_dec: assert property (@(posedge clk_sys) disable iff (rst)
    doPush |=> spLow == $past(spLow) - 8'h01) else $error("push not decrementing");
  a_pop_inc: assert property (@(posedge clk_sys) disable iff (rst)
    doPop |=> spLow == $past(spLow) + 8'h01) else $error("pop not incrementing");
  a_wrap_push: assert property (@(posedge clk_sys) disable iff (rst)
    (doPush && spLow == 8'h00) |=> spLow == 8'hff)
    else $error("push did not wrap");
  a_sp_reinit: assert property (@(posedge clk_sys) disable iff (rst)
    (opCode == ccsp_pkg::OP_SP_RESET && !active) |=> spLow == 8'hff)
    else $error("reinit failed");
  a_sp_load: assert property (@(posedge clk_sys) disable iff (rst)
    (opCode == ccsp_pkg::OP_SP_LOAD && !active) |=> spLow == $past(writeData))
    else $error("pointer load failed");

  // Stack strobes and frame shape
  a_write_addr: assert property (@(posedge clk_sys) disable iff (rst)
    doPush |=> stackWrite && stack_top_pointer[7:0] == $past(spLow))
    else $error("push address wrong");
  a_read_addr: assert property (@(posedge clk_sys) disable iff (rst)
    doPop |=> stackRead && stack_top_pointer[7:0] == $past(spLow) + 8'h01)
    else $error("pop address wrong");
  a_first_slot: assert property (@(posedge clk_sys) disable iff (rst)
    (doPush && remaining == frameLen) |=> frameIndex == 3'h0)
    else $error("first pushed byte not slot zero");
  a_irq_frame: assert property (@(posedge clk_sys) disable iff (rst)
    (seqStart == ccsp_pkg::SEQ_IRQ && !active) |=> doPush [*5] ##1 !doPush)
    else $error("interrupt frame not five bytes");
  a_interrupt_return_instruction_frame: assert property (@(posedge clk_sys) disable iff (rst)
    (seqStart == ccsp_pkg::SEQ_INTERRUPT_RETURN_INSTRUCTION && !active) |=> doPop [*5] ##1 !doPop)
    else $error("return frame not five bytes");
  a_call_frame: assert property (@(posedge clk_sys) disable iff (rst)
    (seqStart == ccsp_pkg::SEQ_CALL && !active) |=> doPush [*2] ##1 !doPush)
    else $error("call frame not two bytes");
  a_ret_frame: assert property (@(posedge clk_sys) disable iff (rst)
    (seqStart == ccsp_pkg::SEQ_RET && !active) |=> doPop [*2] ##1 !doPop)
    else $error("return not two bytes");
  a_busy_refuse: assert property (@(posedge clk_sys) disable iff (rst)
    (active && remaining != 3'h1) |=> frameLen == $past(frameLen) && active)
    else $error("request taken while busy");

  // Priority bits
  a_prio_load: assert property (@(posedge clk_sys) disable iff (rst)
    (seqStart == ccsp_pkg::SEQ_IRQ && !active) |=> {ccStore[5], ccStore[3]} == $past(vectorPriority))
    else $error("priority not loaded");
  a_prio_mask: assert property (@(posedge clk_sys) disable iff (rst)
    (opCode == ccsp_pkg::OP_MASK && opFree) |=> ccStore[5] && ccStore[3])
    else $error("mask level wrong");
  a_prio_unmask: assert property (@(posedge clk_sys) disable iff (rst)
    (opCode == ccsp_pkg::OP_UNMASK && opFree) |=> ccStore[5] && !ccStore[3])
    else $error("main level wrong");
  a_restore_read: assert property (@(posedge clk_sys) disable iff (rst)
    restoreNext |-> stackRead) else $error("restore outside read strobe");
  a_interrupt_return_instruction_restore: assert property (@(posedge clk_sys) disable iff (rst)
    restoreNext |=> ccStore == ($past(popData) | ccsp_pkg::CC_FIXED))
    else $error("context not restored");

  // Arithmetic flags
  a_half_flag: assert property (@(posedge clk_sys) disable iff (rst)
    (opCode == ccsp_pkg::OP_ADD && opFree) |=> ccStore[4] == $past(halfCarry))
    else $error("half carry wrong");
  a_half_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (opCode == ccsp_pkg::OP_ADD && opFree && !halfCarry) |=> !ccStore[4])
    else $error("half carry not cleared");
  a_neg_flag: assert property (@(posedge clk_sys) disable iff (rst)
    (opCode inside {ccsp_pkg::OP_ADD, ccsp_pkg::OP_LOGIC} && opFree)
    |=> ccStore[2] == $past(result[7]))
    else $error("negative flag wrong");
  a_zero_flag: assert property (@(posedge clk_sys) disable iff (rst)
    (opCode == ccsp_pkg::OP_LOGIC && opFree) |=> ccStore[1] == ($past(result) == 8'h00))
    else $error("zero flag wrong");
  a_carry_arith: assert property (@(posedge clk_sys) disable iff (rst)
    (opCode == ccsp_pkg::OP_ARITH && opFree) |=> ccStore[0] == $past(carryOut))
    else $error("carry flag wrong");
  a_carry_set: assert property (@(posedge clk_sys) disable iff (rst)
    (opCode == ccsp_pkg::OP_CARRY_SET && opFree) |=> ##1 condition_code_register[0])
    else $error("carry not set");
  a_carry_clr: assert property (@(posedge clk_sys) disable iff (rst)
    (opCode == ccsp_pkg::OP_CARRY_CLR && opFree) |=> ##1 !condition_code_register[0])
    else $error("carry not cleared");

  // Branch outcome
  a_branch_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (branchCond == ccsp_pkg::BR_ZERO) |=> branchTaken == $past(ccStore[1]))
    else $error("zero branch wrong");
  a_branch_nocarry: assert property (@(posedge clk_sys) disable iff (rst)
    (branchCond == ccsp_pkg::BR_NOCARRY) |=> branchTaken == !$past(ccStore[0]))
    else $error("no carry branch wrong");
endmodule

// >>> core_stack_model.sv
`timescale 1ns/10ps
module core_stack_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic stackWrite,
  input wire logic stackRead,
  input wire logic [15:0] stack_top_pointer,
  input wire logic [2:0] frameIndex,
  input wire logic [7:0] savedCc,
  output logic [7:0] popData,
  output int nWrite,
  output int nRead
);
  logic [15:0] wrLog [0:63];
  logic [2:0] idxLog [0:63];
  // Saved byte only while a pop runs, inverted otherwise
  assign popData = stackRead ? savedCc : ~savedCc;
  // Log of every pushed address and count of pops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nWrite <= 0;
      nRead <= 0;
    end else begin
      if (stackWrite) begin
        wrLog[nWrite[5:0]] <= stack_top_pointer;
        idxLog[nWrite[5:0]] <= frameIndex;
        nWrite <= nWrite + 1;
      end
      if (stackRead) begin
        nRead <= nRead + 1;
      end
    end
  end
endmodule

// >>> tb_cpu_flags_stack_pointer.sv
`timescale 1ns/10ps
module tb_cpu_flags_stack_pointer;
  logic clk_sys, rst, carryOut, halfCarry, stackWrite, stackRead, seqBusy, branchTaken;
  ccsp_pkg::op_e opCode;
  ccsp_pkg::seq_e seqStart;
  ccsp_pkg::br_e branchCond;
  logic [7:0] result, writeData, popData, condition_code_register, savedCc;
  logic [1:0] vectorPriority, pr;
  logic [15:0] stack_top_pointer, sp;
  logic [2:0] frameIndex;
  logic h, n, z, c;
  int n_mismatch, tests_run, nWrite, nRead;
  ccsp_pkg::op_e ops [9] = '{ccsp_pkg::OP_ADD, ccsp_pkg::OP_ARITH, ccsp_pkg::OP_LOGIC,
    ccsp_pkg::OP_CARRY_SET, ccsp_pkg::OP_CARRY_CLR, ccsp_pkg::OP_UNMASK,
    ccsp_pkg::OP_MASK, ccsp_pkg::OP_CC_WRITE, ccsp_pkg::OP_ADD};

  cpu_flags_stack_pointer uut (.clk_sys, .rst, .opCode, .result, .carryOut, .halfCarry,
    .writeData, .seqStart, .vectorPriority, .popData, .branchCond, .condition_code_register,
    .stack_top_pointer, .stackWrite, .stackRead, .frameIndex, .seqBusy, .branchTaken);
  core_stack_model model (.clk_sys, .rst, .stackWrite, .stackRead, .stack_top_pointer, .frameIndex,
    .savedCc, .popData, .nWrite, .nRead);

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and closing
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] cc();
    return {2'b11, pr[1], h, pr[0], n, z, c};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // One core operation, then flags, pointer and all branch senses
  task automatic doOp(input ccsp_pkg::op_e o, input logic [7:0] r, input logic cy, hc);
    logic [7:0] e;
    logic [3:0] f;
    @(negedge clk_sys);
    opCode = o;
    result = r;
    writeData = r;
    carryOut = cy;
    halfCarry = hc;
    @(negedge clk_sys);
    opCode = ccsp_pkg::OP_NONE;
    @(negedge clk_sys);
    case (o)
      ccsp_pkg::OP_ADD: {h, c, n, z} = {hc, cy, r[7], r == 8'h00};
      ccsp_pkg::OP_ARITH: {c, n, z} = {cy, r[7], r == 8'h00};
      ccsp_pkg::OP_LOGIC: {n, z} = {r[7], r == 8'h00};
      ccsp_pkg::OP_SHIFT: {c, n, z} = {cy, r[7], r == 8'h00};
      ccsp_pkg::OP_BITTEST: c = cy;
      ccsp_pkg::OP_CARRY_SET: c = 1'b1;
      ccsp_pkg::OP_CARRY_CLR: c = 1'b0;
      ccsp_pkg::OP_UNMASK: pr = ccsp_pkg::PRIO_MAIN;
      ccsp_pkg::OP_MASK: pr = ccsp_pkg::PRIO_DISABLE;
      ccsp_pkg::OP_CC_WRITE: {pr[1], h, pr[0], n, z, c} = r[5:0];
      ccsp_pkg::OP_SP_LOAD: sp = {8'h01, r};
      ccsp_pkg::OP_SP_RESET: sp = 16'h01ff;
      default: ;
    endcase
    e = cc();
    check({8'h00, condition_code_register}, {8'h00, e});
    check({8'h00, condition_code_register[5:0], 2'h0}, {8'h00, e[5:0], 2'h0});
    check(stack_top_pointer, sp);
    f = {c, z, n, h};
    for (int b = 0; b < 8; b++) begin
      branchCond = ccsp_pkg::br_e'(b);
      @(negedge clk_sys);
      @(negedge clk_sys);
      check({15'h0, branchTaken}, {15'h0, f[b / 2] ^ b[0]});
    end
  endtask

  // One stack sequence, optionally with a second request while busy
  task automatic doSeq(input ccsp_pkg::seq_e s, input logic [1:0] vp, input bit rep);
    int wr, rd, k, len;
    wr = nWrite;
    rd = nRead;
    k = 0;
    len = (s == ccsp_pkg::SEQ_PUSH || s == ccsp_pkg::SEQ_POP) ? 1 :
          (s == ccsp_pkg::SEQ_IRQ || s == ccsp_pkg::SEQ_INTERRUPT_RETURN_INSTRUCTION) ? 5 : 2;
    @(negedge clk_sys);
    seqStart = s;
    vectorPriority = vp;
    @(negedge clk_sys);
    seqStart = rep ? ccsp_pkg::SEQ_CALL : ccsp_pkg::SEQ_NONE;
    @(negedge clk_sys);
    seqStart = ccsp_pkg::SEQ_NONE;
    while (seqBusy !== 1'b0 && k < 20) begin
      @(negedge clk_sys);
      k++;
    end
    @(negedge clk_sys);
    if (s == ccsp_pkg::SEQ_PUSH || s == ccsp_pkg::SEQ_CALL || s == ccsp_pkg::SEQ_IRQ) begin
      check(16'(nWrite - wr), 16'(len));
      check(model.wrLog[6'(wr)], sp);
      check({13'h0, model.idxLog[6'(wr)]}, 16'h0000);
      check({13'h0, model.idxLog[6'(wr + len - 1)]}, 16'(len - 1));
      check(model.wrLog[6'(wr + len - 1)], {8'h01, sp[7:0] - 8'(len - 1)});
      sp = {8'h01, sp[7:0] - 8'(len)};
    end else begin
      check(16'(nRead - rd), 16'(len));
      sp = {8'h01, sp[7:0] + 8'(len)};
    end
    if (s == ccsp_pkg::SEQ_IRQ) pr = vp;
    if (s == ccsp_pkg::SEQ_INTERRUPT_RETURN_INSTRUCTION) {pr[1], h, pr[0], n, z, c} = savedCc[5:0];
    check({8'h00, condition_code_register}, {8'h00, cc()});
    check(stack_top_pointer, sp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h2c40));
    {rst, carryOut, halfCarry, result, writeData, vectorPriority} = {1'b1, 20'h0};
    opCode = ccsp_pkg::OP_NONE;
    seqStart = ccsp_pkg::SEQ_NONE;
    branchCond = ccsp_pkg::BR_HALF;
    savedCc = 8'h35;
    {h, n, z, c, pr, sp} = {4'ha, 2'h3, 16'h01ff};
    n_mismatch = 0;
    tests_run = 0;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    check({8'h00, condition_code_register}, 16'h00fa);
    check(stack_top_pointer, 16'h01ff);
    $display("reset test done");
    doOp(ccsp_pkg::OP_ADD, 8'h00, 1'b1, 1'b1);
    doOp(ccsp_pkg::OP_SHIFT, 8'h7f, 1'b0, 1'b0);
    doOp(ccsp_pkg::OP_ADD, 8'h80, 1'b0, 1'b0);
    doOp(ccsp_pkg::OP_BITTEST, 8'h01, 1'b1, 1'b0);
    doOp(ccsp_pkg::OP_CC_WRITE, 8'h00, 1'b0, 1'b0);
    for (int i = 0; i < 24; i++) begin
      doOp(ops[$urandom_range(0, 8)], 8'($urandom), 1'($urandom), 1'($urandom));
    end
    $display("flag test done");
    doSeq(ccsp_pkg::SEQ_CALL, 2'h0, 1'b0);
    doSeq(ccsp_pkg::SEQ_PUSH, 2'h0, 1'b0);
    doSeq(ccsp_pkg::SEQ_POP, 2'h0, 1'b0);
    doSeq(ccsp_pkg::SEQ_RET, 2'h0, 1'b0);
    for (int v = 0; v < 4; v++) begin
      savedCc = 8'($urandom);
      doSeq(ccsp_pkg::SEQ_IRQ, 2'(v), 1'b1);
      doSeq(ccsp_pkg::SEQ_INTERRUPT_RETURN_INSTRUCTION, 2'h0, 1'b0);
    end
    $display("frame test done");
    doOp(ccsp_pkg::OP_SP_LOAD, 8'h01, 1'b0, 1'b0);
    doSeq(ccsp_pkg::SEQ_CALL, 2'h0, 1'b0);
    doSeq(ccsp_pkg::SEQ_RET, 2'h0, 1'b0);
    doOp(ccsp_pkg::OP_SP_RESET, 8'h00, 1'b0, 1'b0);
    $display("wrap test done");
    final_report();
  end

  // Cuts a hang short well beyond the expected run time
  initial begin
    #40000;
    n_mismatch++;
    final_report();
  end
endmodule
